// *** hw/pcm_master.v ***
// pcm digital audio master: bit clock, frame sync, 16-bit full duplex shifting
// assumes a 50 MHz system clock, a plain register port and an external codec as slave
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.vh"

module pcm_master (
	// clock and reset
	input wire i_clock,
	input wire i_rst_n,
	// register port
	input wire [7:0] i_reg_addr,
	input wire [15:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire i_reg_rd,
	output reg [15:0] o_reg_rdata,
	// transmit words in
	input wire i_tx_valid,
	input wire [15:0] i_tx_data,
	output wire o_tx_ready,
	// received words out
	output reg o_rx_valid,
	output reg [15:0] o_rx_data,
	// codec pins
	output reg o_pcm_clk,
	output reg o_pcm_sync,
	output reg o_pcm_out,
	output reg o_pcm_out_oe,
	input wire i_pcm_in
);

	// counts worked out at full integer width, then cut to the counter widths
	localparam integer FRAME_I = (`PCM_FRAME_NS * `PCM_CLK_MHZ) / 1000;
	localparam integer SYNC_I = (`PCM_SYNC_HIGH_NS * `PCM_CLK_MHZ) / 1000;
	localparam integer H256_I = `PCM_CLK_HZ / (2 * `PCM_RATE_256K);
	localparam integer H512_I = `PCM_CLK_HZ / (2 * `PCM_RATE_512K);
	localparam integer H102_I = `PCM_CLK_HZ / (2 * `PCM_RATE_102K);
	localparam integer H2048_I = `PCM_CLK_HZ / (2 * `PCM_RATE_2048K);
	localparam integer H1M_I = `PCM_CLK_HZ / (2 * `PCM_RATE_1M);
	localparam integer BITS_I = `PCM_WORD_BITS;
	localparam [12:0] FRAME_CYC = FRAME_I[12:0];
	localparam [12:0] SYNC_CYC = SYNC_I[12:0];
	localparam [8:0] HALF_256K = H256_I[8:0];
	localparam [8:0] HALF_512K = H512_I[8:0];
	localparam [8:0] HALF_102K = H102_I[8:0];
	localparam [8:0] HALF_2048K = H2048_I[8:0];
	localparam [8:0] HALF_1M = H1M_I[8:0];
	localparam [4:0] WORD_BITS = BITS_I[4:0];
	localparam [4:0] LAST_BIT = WORD_BITS - 5'h01;

	// register state
	reg [15:0] ctrl_ff;
	reg underrun_ff;
	reg rxnew_ff;
	reg [15:0] rxword_ff;
	// frame and bit clock state
	reg [12:0] frame_cnt_ff;
	reg [8:0] half_ff;
	reg [8:0] half_cnt_ff;
	reg long_ff;
	reg zpad_ff;
	reg rise_ff;
	reg rise_d1_ff;
	reg rise_d2_ff;
	// shifters
	reg [15:0] tx_sh_ff;
	reg [4:0] tx_cnt_ff;
	reg [15:0] rx_sh_ff;
	reg [4:0] rx_cnt_ff;
	// input synchroniser
	reg din_s1_ff;
	reg din_s2_ff;
	// combinational
	reg [8:0] nxt_half;
	wire enable;
	wire frame_start;
	wire half_tick;
	wire fall_evt;
	wire [13:0] long_cyc;
	wire sync_level;
	wire fifo_valid;
	wire [15:0] fifo_data;
	wire [3:0] fifo_level;
	wire fifo_full;
	wire pop;
	wire rx_done;
	wire clr_underrun;
	wire clr_rxnew;

	assign enable = ctrl_ff[`PCM_CTRL_EN];
	assign frame_start = enable & (frame_cnt_ff == 13'h0000);
	assign half_tick = enable & ~frame_start & (half_cnt_ff == 9'h000);
	assign fall_evt = half_tick & o_pcm_clk;
	assign pop = frame_start;
	assign fifo_full = (fifo_level == 4'h8);
	assign rx_done = rise_d2_ff & (rx_cnt_ff == LAST_BIT);
	assign clr_underrun = i_reg_wr & (i_reg_addr == `PCM_REG_STATUS) & i_reg_wdata[`PCM_STAT_UNDERRUN];
	assign clr_rxnew = i_reg_wr & (i_reg_addr == `PCM_REG_STATUS) & i_reg_wdata[`PCM_STAT_RXNEW];

	// transmit word buffer, drained once per frame
	pcm_fifo #(
		.WIDTH(`PCM_FIFO_WIDTH),
		.DEPTH(`PCM_FIFO_DEPTH),
		.AW(3)
	) u_tx_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_wr_valid(i_tx_valid),
		.i_wr_data(i_tx_data),
		.o_wr_ready(o_tx_ready),
		.o_rd_valid(fifo_valid),
		.o_rd_data(fifo_data),
		.i_rd_ready(pop),
		.o_level(fifo_level)
	);

	// half bit period for the selected rate
	always @* begin
		case (ctrl_ff[`PCM_CTRL_RATE_HI:`PCM_CTRL_RATE_LO])
			`PCM_SEL_256K: nxt_half = HALF_256K;
			`PCM_SEL_512K: nxt_half = HALF_512K;
			`PCM_SEL_102K: nxt_half = HALF_102K;
			`PCM_SEL_2048K: nxt_half = HALF_2048K;
			`PCM_SEL_1M: nxt_half = HALF_1M;
			default: nxt_half = HALF_1M;
		endcase
	end

	// control, status and received-word registers
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_ff <= `PCM_CTRL_RESET;
			underrun_ff <= 1'b0;
			rxnew_ff <= 1'b0;
			rxword_ff <= 16'h0000;
		end else begin
			if (i_reg_wr && (i_reg_addr == `PCM_REG_CTRL))
				ctrl_ff <= {10'h000, i_reg_wdata[5:0]};
			// a new event beats a clear in the same cycle
			if (pop && !fifo_valid)
				underrun_ff <= 1'b1;
			else if (clr_underrun)
				underrun_ff <= 1'b0;
			if (rx_done)
				rxnew_ff <= 1'b1;
			else if (clr_rxnew)
				rxnew_ff <= 1'b0;
			if (rx_done)
				rxword_ff <= {rx_sh_ff[14:0], din_s2_ff};
		end
	end

	// read data stands for the one cycle after the strobe
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 16'h0000;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				`PCM_REG_CTRL: o_reg_rdata <= ctrl_ff;
				`PCM_REG_STATUS: o_reg_rdata <= {12'h000, rxnew_ff, underrun_ff, fifo_full, ~fifo_valid};
				`PCM_REG_RXWORD: o_reg_rdata <= rxword_ff;
				`PCM_REG_LEVEL: o_reg_rdata <= {12'h000, fifo_level};
				default: o_reg_rdata <= 16'h0000;
			endcase
		end else begin
			o_reg_rdata <= 16'h0000;
		end
	end

	// frame counter: one frame every 125 us, 8 kHz
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_cnt_ff <= 13'h0000;
		end else if (!enable) begin
			frame_cnt_ff <= 13'h0000;
		end else if (frame_cnt_ff == FRAME_CYC - 13'h0001) begin
			frame_cnt_ff <= 13'h0000;
		end else begin
			frame_cnt_ff <= frame_cnt_ff + 13'h0001;
		end
	end

	// rate, sync format and padding are taken at frame start only
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			half_ff <= HALF_1M;
			long_ff <= 1'b0;
			zpad_ff <= 1'b0;
		end else if (frame_start) begin
			half_ff <= nxt_half;
			long_ff <= ctrl_ff[`PCM_CTRL_LONG];
			zpad_ff <= ctrl_ff[`PCM_CTRL_ZPAD];
		end
	end

	// long sync covers sixteen bit periods
	assign long_cyc = {half_ff, 5'h00};
	assign sync_level = long_ff ? ({1'b0, frame_cnt_ff} < long_cyc) : (frame_cnt_ff < SYNC_CYC);

	// frame sync output
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pcm_sync <= 1'b0;
		end else if (!enable) begin
			o_pcm_sync <= 1'b0;
		end else if (frame_start) begin
			o_pcm_sync <= 1'b1;
		end else begin
			o_pcm_sync <= sync_level;
		end
	end

	// bit clock divider; phase restarts low with the sync rise so the first
	// rising edge comes half a bit period after the sync edge
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pcm_clk <= 1'b0;
			half_cnt_ff <= HALF_1M - 9'h001;
			rise_ff <= 1'b0;
		end else if (!enable) begin
			o_pcm_clk <= 1'b0;
			half_cnt_ff <= HALF_1M - 9'h001;
			rise_ff <= 1'b0;
		end else if (frame_start) begin
			o_pcm_clk <= 1'b0;
			half_cnt_ff <= nxt_half - 9'h001;
			rise_ff <= 1'b0;
		end else if (half_tick) begin
			o_pcm_clk <= ~o_pcm_clk;
			half_cnt_ff <= half_ff - 9'h001;
			rise_ff <= ~o_pcm_clk;
		end else begin
			half_cnt_ff <= half_cnt_ff - 9'h001;
			rise_ff <= 1'b0;
		end
	end

	// transmit shifter: msb driven with the sync rise, later bits change on falling edges
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_sh_ff <= 16'h0000;
			tx_cnt_ff <= 5'h00;
			o_pcm_out <= 1'b0;
			o_pcm_out_oe <= 1'b0;
		end else if (!enable) begin
			tx_cnt_ff <= WORD_BITS;
			o_pcm_out <= 1'b0;
			o_pcm_out_oe <= 1'b0;
		end else if (frame_start) begin
			tx_sh_ff <= fifo_valid ? fifo_data : 16'h0000;
			o_pcm_out <= fifo_valid ? fifo_data[15] : 1'b0;
			o_pcm_out_oe <= 1'b1;
			tx_cnt_ff <= 5'h00;
		end else if (fall_evt && tx_cnt_ff != WORD_BITS) begin
			tx_cnt_ff <= tx_cnt_ff + 5'h01;
			if (tx_cnt_ff == LAST_BIT) begin
				o_pcm_out <= 1'b0;
				o_pcm_out_oe <= zpad_ff;
			end else begin
				tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
				o_pcm_out <= tx_sh_ff[14];
			end
		end
	end

	// two-flop synchroniser for the codec data pin
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			din_s1_ff <= 1'b0;
			din_s2_ff <= 1'b0;
		end else begin
			din_s1_ff <= i_pcm_in;
			din_s2_ff <= din_s1_ff;
		end
	end

	// rising-edge strobe delayed to match the synchroniser
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rise_d1_ff <= 1'b0;
			rise_d2_ff <= 1'b0;
		end else begin
			rise_d1_ff <= rise_ff;
			rise_d2_ff <= rise_d1_ff;
		end
	end

	// receive shifter: samples taken at bit clock rising edges
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_sh_ff <= 16'h0000;
			rx_cnt_ff <= 5'h00;
		end else if (frame_start) begin
			rx_cnt_ff <= 5'h00;
		end else if (rise_d2_ff && rx_cnt_ff != WORD_BITS) begin
			rx_sh_ff <= {rx_sh_ff[14:0], din_s2_ff};
			rx_cnt_ff <= rx_cnt_ff + 5'h01;
		end
	end

	// received word handed out as a one-cycle pulse
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rx_valid <= 1'b0;
			o_rx_data <= 16'h0000;
		end else begin
			o_rx_valid <= rx_done;
			if (rx_done)
				o_rx_data <= {rx_sh_ff[14:0], din_s2_ff};
		end
	end

endmodule

`default_nettype wire

// *** shared/pcm_map.vh ***
// constants of the pcm digital audio master: offsets, fields, reset values, timing
// assumes a 50 MHz system clock and a 16-bit plain register port
`ifndef PCM_MAP_VH
`define PCM_MAP_VH

// system clock
`define PCM_CLK_HZ 50000000
`define PCM_CLK_MHZ 50

// bit clock rates in hertz
`define PCM_RATE_256K 256000
`define PCM_RATE_512K 512000
`define PCM_RATE_102K 102000
`define PCM_RATE_2048K 2048000
`define PCM_RATE_1M 1000000

// rate select codes
`define PCM_SEL_256K 3'h0
`define PCM_SEL_512K 3'h1
`define PCM_SEL_102K 3'h2
`define PCM_SEL_2048K 3'h3
`define PCM_SEL_1M 3'h4

// frame timing in nanoseconds
`define PCM_FRAME_NS 125000
`define PCM_SYNC_HIGH_NS 1000
`define PCM_SYNC_CLK_NS 651
`define PCM_BITCLK_PERIOD_NS 1302

// word format
`define PCM_WORD_BITS 16
`define PCM_LONG_SYNC_BITS 16

// transmit buffer
`define PCM_FIFO_WIDTH 16
`define PCM_FIFO_DEPTH 8

// register offsets
`define PCM_REG_CTRL 8'h00
`define PCM_REG_STATUS 8'h04
`define PCM_REG_RXWORD 8'h08
`define PCM_REG_LEVEL 8'h0C

// control fields
`define PCM_CTRL_EN 0
`define PCM_CTRL_LONG 1
`define PCM_CTRL_ZPAD 2
`define PCM_CTRL_RATE_LO 3
`define PCM_CTRL_RATE_HI 5
`define PCM_CTRL_RESET 16'h0021

// status fields
`define PCM_STAT_EMPTY 0
`define PCM_STAT_FULL 1
`define PCM_STAT_UNDERRUN 2
`define PCM_STAT_RXNEW 3

`endif

// *** hw/pcm_fifo.v ***
// word fifo with valid/ready on both sides, flip-flop storage
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module pcm_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire i_clock,
	input wire i_rst_n,
	// fill side
	input wire i_wr_valid,
	input wire [WIDTH-1:0] i_wr_data,
	output wire o_wr_ready,
	// drain side
	output wire o_rd_valid,
	output wire [WIDTH-1:0] o_rd_data,
	input wire i_rd_ready,
	// fill level
	output wire [AW:0] o_level
);

	localparam [AW:0] FULL_CNT = DEPTH[AW:0];

	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] count_ff;
	reg ready_ff;
	reg empty_ff;
	wire do_wr;
	wire do_rd;
	reg [AW:0] nxt_count;

	assign do_wr = i_wr_valid & ready_ff;
	assign do_rd = i_rd_ready & ~empty_ff;
	assign o_wr_ready = ready_ff; // straight from a flop, no gate behind it
	assign o_rd_valid = ~empty_ff;
	assign o_rd_data = mem_ff[rd_ptr_ff];
	assign o_level = count_ff;

	// next fill count
	always @* begin
		nxt_count = count_ff;
		if (do_wr & ~do_rd)
			nxt_count = count_ff + {{AW{1'b0}}, 1'b1};
		else if (do_rd & ~do_wr)
			nxt_count = count_ff - {{AW{1'b0}}, 1'b1};
	end

	// pointers and flags
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
			ready_ff <= 1'b1;
			empty_ff <= 1'b1;
		end else begin
			if (do_wr)
				wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
			if (do_rd)
				rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
			count_ff <= nxt_count;
			ready_ff <= (nxt_count != FULL_CNT);
			empty_ff <= (nxt_count == {(AW+1){1'b0}});
		end
	end

	// storage, no reset needed
	always @(posedge i_clock) begin
		if (do_wr)
			mem_ff[wr_ptr_ff] <= i_wr_data;
	end

endmodule

`default_nettype wire

// *** tb/pcm_codec_model.sv ***
// behavioural codec on the far side of the pcm pins
// assumes the system clock to find the master's clock and sync edges
`timescale 1ns/1ps
`default_nettype none
module pcm_codec_model (
	// clock
	input wire logic i_clock,
	// pins seen from the codec
	input wire logic i_bit_clk,
	input wire logic i_sync,
	input wire logic i_data,
	output logic o_data,
	// word to send and last word received
	input wire logic [15:0] i_word,
	output logic [15:0] o_got
);
	logic clk_d = 1'b0;
	logic sync_d = 1'b0;
	logic [15:0] tx_sh = 16'h0000;
	logic [15:0] rx_sh = 16'h0000;
	int rises = 16;
	initial o_data = 1'b0;
	initial o_got = 16'h0000;
	// edges of the master's pins; outside the word the line keeps toggling
	always @(posedge i_clock) begin
		clk_d <= i_bit_clk;
		sync_d <= i_sync;
		if (i_sync && !sync_d) begin
			tx_sh <= i_word;
			rises <= 0;
			o_data <= i_word[15];
		end else if (i_bit_clk && !clk_d && rises < 16) begin
			rx_sh <= {rx_sh[14:0], i_data};
			rises <= rises + 1;
			if (rises == 15) o_got <= {rx_sh[14:0], i_data};
		end else if (!i_bit_clk && clk_d) begin
			tx_sh <= {tx_sh[14:0], 1'b0};
			o_data <= (rises < 16) ? tx_sh[14] : ~o_data;
		end
	end
endmodule
`default_nettype wire

// *** tb/pcm_master_assertions.sv ***
// timing checks on the pcm pins of the master
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pcm_master_checker (
	// clock and reset
	input wire i_clock,
	input wire i_rst_n,
	// watched outputs
	input wire o_pcm_clk,
	input wire o_pcm_sync,
	input wire o_pcm_out,
	input wire o_pcm_out_oe,
	input wire o_rx_valid
);
	logic sync_d_ff;
	logic seen_ff;
	logic [12:0] gap_ff;
	logic [12:0] hi_ff;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// cycles since the last frame start and length of the sync pulse
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_d_ff <= 1'b0;
			seen_ff <= 1'b0;
			gap_ff <= 13'h0000;
			hi_ff <= 13'h0000;
		end else begin
			sync_d_ff <= o_pcm_sync;
			hi_ff <= o_pcm_sync ? hi_ff + 13'h0001 : 13'h0000;
			if (o_pcm_sync && !sync_d_ff) begin
				gap_ff <= 13'h0000;
				seen_ff <= 1'b1;
			end else begin
				gap_ff <= gap_ff + 13'h0001;
			end
		end
	end
	sequence s_start;
		$rose(o_pcm_sync);
	endsequence
	sequence s_clk_low8;
		(!o_pcm_clk)[*8];
	endsequence
	AST_FRAME_PERIOD: assert property ($rose(o_pcm_sync) && seen_ff |-> gap_ff == 13'h1869)
		else $error("frame period not 6250 cycles");
	AST_SYNC_WIDTH: assert property ($fell(o_pcm_sync) |-> hi_ff == 13'h0032 || hi_ff >= 13'h0180)
		else $error("sync pulse width wrong");
	AST_SYNC_CLK_LOW: assert property ($changed(o_pcm_sync) |-> !$rose(o_pcm_clk))
		else $error("sync moved on a rising bit clock edge");
	AST_CLK_DELAY: assert property (s_start |-> s_clk_low8)
		else $error("bit clock rose too soon after sync");
	AST_OE_AT_START: assert property (s_start |-> o_pcm_out_oe)
		else $error("data pin not driven at frame start");
	AST_OUT_ON_FALL: assert property ($changed(o_pcm_out) |-> $fell(o_pcm_clk) || $rose(o_pcm_sync))
		else $error("data changed off a falling bit clock");
	AST_OE_OFF_QUIET: assert property (!o_pcm_out_oe |-> !o_pcm_out)
		else $error("data high while released");
	AST_RX_PULSE: assert property (o_rx_valid |=> !o_rx_valid)
		else $error("receive pulse longer than one cycle");
endmodule
bind pcm_master pcm_master_checker pcm_master_checker_i (
	.i_clock(i_clock),
	.i_rst_n(i_rst_n),
	.o_pcm_clk(o_pcm_clk),
	.o_pcm_sync(o_pcm_sync),
	.o_pcm_out(o_pcm_out),
	.o_pcm_out_oe(o_pcm_out_oe),
	.o_rx_valid(o_rx_valid)
);
`default_nettype wire

// *** tb/pcm_master_tb.sv ***
// testbench of the pcm master: registers, transmit fifo, frames at every rate
// assumes the codec model on the pins and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.vh"
module pcm_master_tb;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tx_valid = 1'b0;
	logic [15:0] tx_data = 16'h0000;
	logic [15:0] codec_word = 16'h0000;
	logic [15:0] rdata, rx_data, got_word, rv;
	logic tx_ready, rx_valid, pcm_clk, pcm_sync, pcm_out, pcm_oe, pcm_in;
	int error_cnt = 0;
	int compares = 0;
	logic [15:0] words [8] = '{16'h8001, 16'h7FFE, 16'hA5C3, 16'h5A3C, 16'hF00F, 16'h0FF0, 16'hC001, 16'h1234};
	logic [15:0] ctrls [8] = '{16'h0021, 16'h0027, 16'h001D, 16'h0009, 16'h0001, 16'h0011, 16'h0021, 16'h0023};
	int halfs [8] = '{25, 25, 12, 48, 97, 245, 25, 25};
	logic [7:0] chks = 8'hCF;
	// system clock
	always #10 i_clock = ~i_clock;
	pcm_master pcm_master_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_pcm_clk(pcm_clk),
		.o_pcm_sync(pcm_sync), .o_pcm_out(pcm_out), .o_pcm_out_oe(pcm_oe), .i_pcm_in(pcm_in));
	pcm_codec_model pcm_codec_model_i (.i_clock(i_clock), .i_bit_clk(pcm_clk), .i_sync(pcm_sync),
		.i_data(pcm_out), .o_data(pcm_in), .i_word(codec_word), .o_got(got_word));
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clock);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic tally_and_finish;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// one frame: set its format, wait for its start, time clock and sync, check both words when chk is set
	task automatic run_frame(input logic [15:0] ctrl, input int h, input bit chk, input logic [15:0] word);
		int clk_at = 0;
		int sync_at = 0;
		int n = 0;
		int n_rx = 0;
		reg_wr(`PCM_REG_CTRL, ctrl);
		codec_word <= ~word;
		#1;
		while (pcm_sync !== 1'b0 && n < 7000) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		while (pcm_sync !== 1'b1 && n < 7000) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		for (int i = 1; i <= 1600; i++) begin
			@(posedge i_clock);
			#1;
			if (clk_at == 0 && pcm_clk === 1'b1) clk_at = i;
			if (sync_at == 0 && pcm_sync === 1'b0) sync_at = i;
			if (rx_valid === 1'b1) n_rx++;
		end
		check("frame start found", {15'h0000, n >= 7000}, 16'h0000);
		check("receive pulses", 16'(n_rx), chk ? 16'h0001 : 16'h0000);
		check("clock delay", 16'(clk_at), 16'(h));
		check("sync width", 16'(sync_at), ctrl[1] ? 16'(32 * h) : 16'h0032);
		if (chk) begin
			check("word to codec", got_word, word);
			check("word from codec", rx_data, ~word);
			check("oe after word", {15'h0000, pcm_oe}, {15'h0000, ctrl[2]});
			check("out after word", {15'h0000, pcm_out}, 16'h0000);
			reg_rd(`PCM_REG_RXWORD, rv);
			check("rx word register", rv, ~word);
		end
	endtask
	// watchdog
	initial begin
		repeat (70000) @(posedge i_clock);
		error_cnt++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		reg_rd(`PCM_REG_CTRL, rv);
		check("ctrl reset", rv, 16'h0021);
		reg_rd(8'h10, rv);
		check("unmapped", rv, 16'h0000);
		@(posedge i_clock);
		for (int k = 0; k < 8; k++) begin
			tx_valid <= 1'b1;
			tx_data <= words[k];
			@(posedge i_clock);
		end
		tx_valid <= 1'b0;
		@(posedge i_clock);
		#1;
		check("ready when full", {15'h0000, tx_ready}, 16'h0000);
		reg_rd(`PCM_REG_LEVEL, rv);
		check("level", rv, 16'h0008);
		reg_rd(`PCM_REG_STATUS, rv);
		check("status when full", rv & 16'h000F, 16'h0006);
		reg_wr(`PCM_REG_STATUS, 16'h0004);
		reg_rd(`PCM_REG_STATUS, rv);
		check("underrun clear when full", rv & 16'h000F, 16'h0002);
		for (int k = 0; k < 8; k++) begin
			run_frame(ctrls[k], halfs[k], chks[k], words[k]);
		end
		run_frame(16'h0021, 25, 1'b1, 16'h0000);
		reg_rd(`PCM_REG_STATUS, rv);
		check("underrun", rv & 16'h0007, 16'h0005);
		reg_wr(`PCM_REG_STATUS, 16'h0004);
		reg_rd(`PCM_REG_STATUS, rv);
		check("underrun cleared", rv & 16'h0007, 16'h0001);
		tally_and_finish();
	end
endmodule
`default_nettype wire
